// *** design/region_attribute_remap.sv ***
// region attribute remap top: remap register, lookup pipeline, register port
// assumes a same-clock master on the register port and on the lookup port
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "remap_defines.svh"

// Notes on behaviour
// - index is type extension bit zero, then cacheable, then bufferable: 0..7
// - two-bit type per index in bits 15:0: strongly ordered, device, normal, reserved
// - bits 31:24 per index: 0 outer shareable for shareable normal, 1 not
// - without inner/outer distinction bits 31:24 read zero and ignore writes
// - normal memory, entry shareable set: final shareability from bit 19
// - normal memory, entry shareable clear: final shareability from bit 18
// - device memory, entry shareable set: final shareability from bit 17
// - device memory, entry shareable clear: final shareability from bit 16
// - index 6 meaning may differ; here it is treated like the rest
// - remap register is 32-bit read-write with no defined reset value
// - remap applies only when the short-descriptor scheme is selected
module region_attribute_remap #(
  parameter bit OUTER_DISTINCT = 1'b1       // inner and outer shareability are told apart
) (
  input wire logic clk_sys,                 // system clock, 200 MHz
  input wire logic rst,                     // synchronous reset, active high
  input wire logic [`REMAP_ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata,        // register write data
  input wire logic reg_write,               // write strobe, one cycle
  input wire logic reg_read,                // read strobe, one cycle
  output logic [31:0] reg_rdata,            // read data, cycle after the strobe
  input wire logic short_descriptor,        // context uses the short-descriptor scheme
  input wire logic lookup_valid,            // lookup request, one cycle
  input wire logic lookup_type_extension_bit0, // entry type extension bit zero
  input wire logic lookup_cacheable,        // entry cacheable bit
  input wire logic lookup_bufferable,       // entry bufferable bit
  input wire logic lookup_shareable,        // entry shareable bit
  output logic result_valid,                // result pulse, cycle after request
  output logic result_applied,              // remap was applied
  output logic [1:0] result_memory_type,    // mapped memory type
  output logic result_shareable,            // mapped shareability
  output logic result_outer_shareable,      // shareable normal, outer shareable
  output logic result_reserved_type,        // type field held the reserved code
  output logic [2:0] result_index           // index the lookup used
);

  // ==========================================================
  // declarations
  localparam logic [31:0] WMASK = OUTER_DISTINCT ? `WMASK_OUTER : `WMASK_FLAT;

  remap_pkg::state_s st;
  remap_pkg::state_s next_st;
  remap_pkg::remap_index_t lookup_index;
  remap_pkg::memory_type_e sel_type;
  logic sel_shareable;
  logic sel_outer;
  logic sel_reserved;
  logic [31:0] status_word;

  // ==========================================================
  // combinational helpers
  remap_index_decode u_index (
    .type_extension_bit0(lookup_type_extension_bit0),
    .cacheable(lookup_cacheable),
    .bufferable(lookup_bufferable),
    .index(lookup_index)
  );

  remap_attr_select #(
    .OUTER_DISTINCT(OUTER_DISTINCT)
  ) u_select (
    .remap_word(st.remap),
    .index(lookup_index),
    .entry_shareable(lookup_shareable),
    .memory_type(sel_type),
    .region_shareable(sel_shareable),
    .outer_shareable(sel_outer),
    .reserved_type(sel_reserved)
  );

  // status word shows the last lookup result
  always_comb begin
    status_word = 32'h0;
    status_word[`ST_APPLIED_BIT] = st.res_applied;
    status_word[`ST_SHAREABLE_BIT] = st.res_shareable;
    status_word[`ST_OUTER_BIT] = st.res_outer;
    status_word[`ST_RESERVED_BIT] = st.res_reserved;
    status_word[`ST_TYPE_LSB +: 2] = st.res_type;
    status_word[`ST_INDEX_LSB +: 3] = st.res_index;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.rd_data = 32'h0;
    next_st.res_valid = lookup_valid;
    // lookup result, one cycle of latency
    if (lookup_valid) begin
      next_st.res_index = lookup_index;
      if (short_descriptor) begin
        next_st.res_applied = 1'b1;
        next_st.res_type = sel_type;
        next_st.res_shareable = sel_shareable;
        next_st.res_outer = sel_outer;
        next_st.res_reserved = sel_reserved;
        next_st.lookup_count = st.lookup_count + 16'h0001;
      end else begin
        // other schemes use indirection, not this remap
        next_st.res_applied = 1'b0;
        next_st.res_type = remap_pkg::mem_strongly_ordered;
        next_st.res_shareable = 1'b0;
        next_st.res_outer = 1'b0;
        next_st.res_reserved = 1'b0;
      end
    end
    // masked write drops reserved and, if flat, outer bits
    if (reg_write && reg_addr == `ADDR_PRIMARY_REMAP) begin
      next_st.remap = reg_wdata & WMASK;
    end
    // read data stands for one cycle only
    if (reg_read) begin
      unique case (reg_addr)
        `ADDR_PRIMARY_REMAP: next_st.rd_data = st.remap;
        `ADDR_LOOKUP_STATUS: next_st.rd_data = status_word;
        `ADDR_LOOKUP_COUNT: next_st.rd_data = {16'h0, st.lookup_count};
        default: next_st.rd_data = 32'h0;
      endcase
    end
    // remap keeps its value through reset: it has none defined
    if (rst) begin
      next_st.rd_data = 32'h0;
      next_st.res_valid = 1'b0;
      next_st.res_applied = 1'b0;
      next_st.res_type = remap_pkg::mem_strongly_ordered;
      next_st.res_shareable = 1'b0;
      next_st.res_outer = 1'b0;
      next_st.res_reserved = 1'b0;
      next_st.res_index = 3'h0;
      next_st.lookup_count = 16'h0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  // outputs come straight from the state flops
  assign reg_rdata = st.rd_data;
  assign result_valid = st.res_valid;
  assign result_applied = st.res_applied;
  assign result_memory_type = st.res_type;
  assign result_shareable = st.res_shareable;
  assign result_outer_shareable = st.res_outer;
  assign result_reserved_type = st.res_reserved;
  assign result_index = st.res_index;

  // ==========================================================
  // checks
  // the remap word is unknown until written once, so lookups are checked after that
  logic remap_known;
  logic [1:0] exp_type;
  logic [7:0] exp_nos;
  logic exp_nos_bit;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      remap_known <= 1'b0;
    end else if (reg_write && reg_addr == `ADDR_PRIMARY_REMAP) begin
      remap_known <= 1'b1;
    end
  end

  // independent view of the fields, from the raw entry bits
  always_comb begin
    exp_type = st.remap[{lookup_type_extension_bit0, lookup_cacheable, lookup_bufferable, 1'b0} +: 2];
    exp_nos = st.remap[31:24];
    // per-index outer bit picked here so the property samples a plain signal
    exp_nos_bit = exp_nos[{lookup_type_extension_bit0, lookup_cacheable, lookup_bufferable}];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence short_lookup_s;
    lookup_valid && short_descriptor && remap_known;
  endsequence

  sequence normal_lookup_s;
    short_lookup_s ##0 exp_type == 2'b10;
  endsequence

  sequence device_lookup_s;
    short_lookup_s ##0 exp_type == 2'b01;
  endsequence

  sequence remap_write_s;
    reg_write && reg_addr == `ADDR_PRIMARY_REMAP;
  endsequence

  sequence remap_read_s;
    reg_read && reg_addr == `ADDR_PRIMARY_REMAP;
  endsequence

  index_order_a: assert property (
    lookup_valid |=> result_valid && result_index == {$past(lookup_type_extension_bit0),
      $past(lookup_cacheable), $past(lookup_bufferable)})
    else $error("result index does not follow type extension, cacheable, bufferable");

  memory_type_a: assert property (
    short_lookup_s |=> result_memory_type == $past(exp_type)
      && result_reserved_type == ($past(exp_type) == 2'b11))
    else $error("mapped memory type differs from the selected field");

  outer_share_a: assert property (
    normal_lookup_s |=> result_outer_shareable == (result_shareable
      && !$past(exp_nos_bit)))
    else $error("outer shareability does not follow the per-index bit");

  flat_outer_a: assert property (
    !OUTER_DISTINCT && remap_known |-> st.remap[`NOS_MSB:`NOS_LSB] == 8'h00)
    else $error("outer shareability bits hold a value without distinction");

  normal_set_a: assert property (
    normal_lookup_s ##0 lookup_shareable |=> result_shareable == $past(st.remap[`NORMAL_SET_BIT]))
    else $error("normal shareable-set mapping wrong");

  normal_clear_a: assert property (
    normal_lookup_s ##0 !lookup_shareable |=> result_shareable == $past(st.remap[`NORMAL_CLEAR_BIT]))
    else $error("normal shareable-clear mapping wrong");

  device_set_a: assert property (
    device_lookup_s ##0 lookup_shareable |=> result_shareable == $past(st.remap[`DEVICE_SET_BIT])
      && !result_outer_shareable)
    else $error("device shareable-set mapping wrong");

  device_clear_a: assert property (
    device_lookup_s ##0 !lookup_shareable |=> result_shareable == $past(st.remap[`DEVICE_CLEAR_BIT]))
    else $error("device shareable-clear mapping wrong");

  remap_readback_a: assert property (
    remap_write_s ##1 remap_read_s |=> reg_rdata == ($past(reg_wdata, 2) & WMASK))
    else $error("remap register read back differs from the masked write");

  scheme_gate_a: assert property (
    lookup_valid && !short_descriptor |=> result_valid && !result_applied
      && result_memory_type == 2'b00 && !result_shareable)
    else $error("remap applied outside the short-descriptor scheme");

  reserved_zero_a: assert property (
    remap_known |-> st.remap[23:20] == 4'h0)
    else $error("reserved remap bits hold a nonzero value");

  read_pulse_a: assert property (
    !reg_read |=> reg_rdata == 32'h0)
    else $error("read data present without a read strobe");

  count_step_a: assert property (
    short_lookup_s |=> st.lookup_count == $past(st.lookup_count) + 16'h0001)
    else $error("lookup count did not advance");

  // ==========================================================
  // strongly ordered and reserved mappings, applied flag, holding behaviour between requests and the read-only views
  strong_order_a: assert property (
    short_lookup_s ##0 exp_type == 2'b00 |=> result_shareable && !result_outer_shareable)
    else $error("strongly ordered region not reported as shareable");

  reserved_code_a: assert property (
    short_lookup_s ##0 exp_type == 2'b11 |=> !result_shareable && !result_outer_shareable)
    else $error("reserved type code reported as shareable");

  result_pulse_a: assert property (
    !lookup_valid |=> !result_valid)
    else $error("result valid without a lookup");

  // consumers may read the result late, so it must not drift between lookups
  result_hold_a: assert property (
    !lookup_valid |=> $stable(result_index) && $stable(result_memory_type) && $stable(result_applied)
      && $stable(result_shareable) && $stable(result_outer_shareable) && $stable(result_reserved_type))
    else $error("lookup result changed without a lookup");

  applied_flag_a: assert property (
    lookup_valid && short_descriptor |=> result_applied)
    else $error("remap not applied in the short-descriptor scheme");

  // only a write to the remap address may move the word once it is known
  remap_hold_a: assert property (
    remap_known && !(reg_write && reg_addr == `ADDR_PRIMARY_REMAP) |=> $stable(st.remap))
    else $error("remap register changed without a write to it");

  count_hold_a: assert property (
    !(lookup_valid && short_descriptor) |=> $stable(st.lookup_count))
    else $error("lookup count moved without an applied lookup");

  count_read_a: assert property (
    reg_read && reg_addr == `ADDR_LOOKUP_COUNT |=> reg_rdata == {16'h0, $past(st.lookup_count)})
    else $error("lookup count read differs from the counter");

  status_view_a: assert property (
    reg_read && reg_addr == `ADDR_LOOKUP_STATUS |=> reg_rdata == {21'h0, $past(result_index), 2'b00,
      $past(result_memory_type), $past(result_reserved_type), $past(result_outer_shareable),
      $past(result_shareable), $past(result_applied)})
    else $error("status read differs from the last lookup result");

  unmapped_read_a: assert property (
    reg_read && reg_addr != `ADDR_PRIMARY_REMAP && reg_addr != `ADDR_LOOKUP_STATUS
      && reg_addr != `ADDR_LOOKUP_COUNT |=> reg_rdata == 32'h0)
    else $error("unmapped address read returned data");

endmodule

`default_nettype wire

// *** shared/remap_defines.svh ***
// register offsets, field positions and masks of the region attribute remap block
// assumes byte addressing over an 8-bit register port, one 32-bit word per register
`ifndef REMAP_DEFINES_SVH
`define REMAP_DEFINES_SVH

// ==========================================================
// register map
`define REMAP_ADDR_W 8
`define ADDR_PRIMARY_REMAP 8'h00
`define ADDR_LOOKUP_STATUS 8'h04
`define ADDR_LOOKUP_COUNT 8'h08

// ==========================================================
// primary_region_remap fields
`define NOS_MSB 31
`define NOS_LSB 24
`define NORMAL_SET_BIT 19
`define NORMAL_CLEAR_BIT 18
`define DEVICE_SET_BIT 17
`define DEVICE_CLEAR_BIT 16
`define WMASK_OUTER 32'hff0fffff
`define WMASK_FLAT 32'h000fffff

// ==========================================================
// lookup status fields
`define ST_APPLIED_BIT 0
`define ST_SHAREABLE_BIT 1
`define ST_OUTER_BIT 2
`define ST_RESERVED_BIT 3
`define ST_TYPE_LSB 4
`define ST_INDEX_LSB 8

`endif

// *** shared/remap_pkg.sv ***
// types shared by the region attribute remap block
// assumes remap_defines.svh is compiled alongside
package remap_pkg;

  // ==========================================================
  // memory types held in the two-bit type fields
  typedef enum logic [1:0] {
    mem_strongly_ordered = 2'b00,
    mem_device = 2'b01,
    mem_normal = 2'b10,
    mem_reserved = 2'b11
  } memory_type_e;

  typedef logic [2:0] remap_index_t;

  // ==========================================================
  // whole state of the remap top
  typedef struct packed {
    logic [31:0] remap;
    logic [31:0] rd_data;
    logic res_valid;
    logic res_applied;
    memory_type_e res_type;
    logic res_shareable;
    logic res_outer;
    logic res_reserved;
    remap_index_t res_index;
    logic [15:0] lookup_count;
  } state_s;

endpackage

// *** design/remap_index_decode.sv ***
// forms the three-bit remap index from the entry attribute bits
// assumes all inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module remap_index_decode (
  input wire logic type_extension_bit0,   // entry type extension bit zero
  input wire logic cacheable,             // entry cacheable bit
  input wire logic bufferable,            // entry bufferable bit
  output remap_pkg::remap_index_t index   // selected index 0..7
);

  // ==========================================================
  // index assembly
  // type extension is the top bit, bufferable the bottom one
  assign index = {type_extension_bit0, cacheable, bufferable};

endmodule

`default_nettype wire

// *** design/remap_attr_select.sv ***
// picks memory type and shareability for one index out of the remap word
// assumes the remap word holds zero in its reserved bits
`timescale 1ns/1ps
`default_nettype none
`include "remap_defines.svh"

module remap_attr_select #(
  parameter bit OUTER_DISTINCT = 1'b1       // inner and outer shareability are told apart
) (
  input wire logic [31:0] remap_word,       // current remap register
  input wire remap_pkg::remap_index_t index, // index from the entry
  input wire logic entry_shareable,         // entry shareable bit
  output remap_pkg::memory_type_e memory_type, // mapped memory type
  output logic region_shareable,            // mapped shareability
  output logic outer_shareable,             // shareable normal that is outer shareable
  output logic reserved_type                // index maps to the reserved type code
);

  logic [7:0] nos_field;
  logic nos_bit;

  // ==========================================================
  // field selection
  // index 6 gets the same treatment as every other index
  always_comb begin
    nos_field = remap_word[`NOS_MSB:`NOS_LSB];
    memory_type = remap_pkg::memory_type_e'(remap_word[{index, 1'b0} +: 2]);
    nos_bit = OUTER_DISTINCT ? nos_field[index] : 1'b0;
    region_shareable = 1'b0;
    outer_shareable = 1'b0;
    reserved_type = 1'b0;
    unique case (memory_type)
      remap_pkg::mem_strongly_ordered: begin
        region_shareable = 1'b1;
      end
      remap_pkg::mem_device: begin
        region_shareable = entry_shareable ? remap_word[`DEVICE_SET_BIT] : remap_word[`DEVICE_CLEAR_BIT];
      end
      remap_pkg::mem_normal: begin
        region_shareable = entry_shareable ? remap_word[`NORMAL_SET_BIT] : remap_word[`NORMAL_CLEAR_BIT];
        outer_shareable = region_shareable & ~nos_bit;
      end
      remap_pkg::mem_reserved: begin
        // unpredictable code: flagged, reported as not shareable
        reserved_type = 1'b1;
      end
    endcase
  end

endmodule

`default_nettype wire

// *** testbench/region_attribute_remap_tb.sv ***
// self-checking bench for the region attribute remap top
// assumes the remap defines header on the include path and the remap package compiled first
`timescale 1ns/1ps
`default_nettype none
`include "remap_defines.svh"

module region_attribute_remap_tb;
  // ==========================================================
  // stimulus and observed signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [`REMAP_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata, flat_rdata, main_seen, flat_seen;
  logic short_descriptor = 1'b0;
  logic lookup_valid = 1'b0;
  logic [2:0] lk_index = 3'h0;
  logic lookup_shareable = 1'b0;
  logic result_valid, result_applied, result_shareable, result_outer_shareable, result_reserved_type;
  logic [1:0] result_memory_type;
  logic [2:0] result_index;
  logic [31:0] results_word;
  logic [31:0] words [2];
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  // main instance with inner and outer shareability told apart
  region_attribute_remap #(.OUTER_DISTINCT(1'b1)) region_attribute_remap_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .short_descriptor(short_descriptor), .lookup_valid(lookup_valid),
    .lookup_type_extension_bit0(lk_index[2]), .lookup_cacheable(lk_index[1]),
    .lookup_bufferable(lk_index[0]), .lookup_shareable(lookup_shareable),
    .result_valid(result_valid), .result_applied(result_applied),
    .result_memory_type(result_memory_type), .result_shareable(result_shareable),
    .result_outer_shareable(result_outer_shareable), .result_reserved_type(result_reserved_type),
    .result_index(result_index));

  // second instance without the distinction, only its register view is judged
  region_attribute_remap #(.OUTER_DISTINCT(1'b0)) region_attribute_remap_flat_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(flat_rdata),
    .short_descriptor(short_descriptor), .lookup_valid(lookup_valid),
    .lookup_type_extension_bit0(lk_index[2]), .lookup_cacheable(lk_index[1]),
    .lookup_bufferable(lk_index[0]), .lookup_shareable(lookup_shareable),
    .result_valid(), .result_applied(), .result_memory_type(), .result_shareable(),
    .result_outer_shareable(), .result_reserved_type(), .result_index());

  // lookup results packed as applied, type, shareable, outer, reserved flag, index
  assign results_word = {23'h0, result_applied, result_memory_type, result_shareable, result_outer_shareable,
                         result_reserved_type, result_index};

  // ==========================================================
  // clock and hang guard
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ceiling well above the roughly 106 cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    compares++;
    if (seen !== expected) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, expected, seen);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // every task starts and ends right after a rising edge, so strobes may follow with no gap
  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
    reg_write <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so capture there
  task automatic reg_rd(input logic [7:0] addr);
    reg_read <= 1'b1;
    reg_addr <= addr;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    main_seen = reg_rdata;
    flat_seen = flat_rdata;
    @(posedge clk_sys);
  endtask

  // packed result: applied, type, shareable, outer, reserved flag, index
  function automatic logic [8:0] expect_result(input logic [31:0] w, input logic [2:0] k,
                                               input logic s, input logic sd);
    logic [1:0] t;
    logic sh;
    logic os;
    t = w[2*k +: 2];
    sh = 1'b0;
    os = 1'b0;
    if (!sd) begin
      return {6'h00, k};
    end
    case (t)
      2'b00: sh = 1'b1;
      2'b01: sh = s ? w[`DEVICE_SET_BIT] : w[`DEVICE_CLEAR_BIT];
      2'b10: begin
        sh = s ? w[`NORMAL_SET_BIT] : w[`NORMAL_CLEAR_BIT];
        os = sh & ~w[`NOS_LSB + k];
      end
      default: sh = 1'b0;
    endcase
    return {1'b1, t, sh, os, t == 2'b11, k};
  endfunction

  // one lookup, result sampled in the cycle after the request
  task automatic lookup(input logic [2:0] k, input logic s, input logic sd, input logic [31:0] w);
    lookup_valid <= 1'b1;
    lk_index <= k;
    lookup_shareable <= s;
    short_descriptor <= sd;
    @(posedge clk_sys);
    lookup_valid <= 1'b0;
    #1;
    check("result_valid", {31'h0, result_valid}, 32'h1);
    check("result", results_word, {23'h0, expect_result(w, k, s, sd)});
    @(posedge clk_sys);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    words[0] = 32'ha50a9ae4;
    words[1] = 32'h5a05651b;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("valid_after_reset", {31'h0, result_valid}, 32'h0);
    check("results_after_reset", results_word, 32'h0);
    check("rdata_after_reset", reg_rdata, 32'h0);
    @(posedge clk_sys);
    // all ones: reserved bits drop, outer bits only where distinct
    reg_wr(`ADDR_PRIMARY_REMAP, 32'hffffffff);
    reg_rd(`ADDR_PRIMARY_REMAP);
    check("remap_all_ones", main_seen, `WMASK_OUTER);
    check("flat_all_ones", flat_seen, `WMASK_FLAT);
    // every index with both entry shareable values, under two mappings
    for (int i = 0; i < 2; i++) begin
      reg_wr(`ADDR_PRIMARY_REMAP, words[i]);
      reg_rd(`ADDR_PRIMARY_REMAP);
      check("remap_word", main_seen, words[i] & `WMASK_OUTER);
      check("flat_word", flat_seen, words[i] & `WMASK_FLAT);
      for (int k = 0; k < 8; k++) begin
        lookup(3'(k), 1'b0, 1'b1, words[i]);
        lookup(3'(k), 1'b1, 1'b1, words[i]);
      end
    end
    // other translation scheme leaves the attributes unmapped
    lookup(3'h5, 1'b1, 1'b0, words[1]);
    reg_rd(`ADDR_LOOKUP_COUNT);
    check("lookup_count", main_seen, 32'h00000020);
    // read-only status ignores writes and still shows the last lookup
    reg_wr(`ADDR_LOOKUP_STATUS, 32'hffffffff);
    reg_rd(`ADDR_LOOKUP_STATUS);
    check("status", main_seen, 32'h00000500);
    reg_rd(8'h0c);
    check("unmapped", main_seen, 32'h00000000);
    reg_rd(`ADDR_PRIMARY_REMAP);
    check("remap_kept", main_seen, words[1] & `WMASK_OUTER);
    // mid-run reset clears results and count; the remap word has no reset of its own
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("valid_after_rerun", {31'h0, result_valid}, 32'h0);
    check("results_after_rerun", results_word, 32'h0);
    @(posedge clk_sys);
    reg_rd(`ADDR_LOOKUP_COUNT);
    check("count_after_rerun", main_seen, 32'h00000000);
    reg_rd(`ADDR_PRIMARY_REMAP);
    check("remap_through_reset", main_seen, words[1] & `WMASK_OUTER);
    conclude();
  end
endmodule
`default_nettype wire
